// File: hw/dbmt_timer.sv
// Purpose: Dual byte match timer, two 8-bit or one 16-bit interval timer
// Assumes: APB master on the same clock; 20 MHz cycle clock
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module dbmt_timer (
    // Clock and reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_n_in,
    // APB slave
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [dbmt_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    input  wire logic [3:0]                  pstrb_in,
    output logic      [31:0]                 prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    // Interrupt requests
    output logic                             irq_high_out,
    output logic                             irq_low_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    dbmt_pkg::dbmt_state_s st_q;
    dbmt_pkg::dbmt_state_s st_d;
    dbmt_pre_if            pre_if ();

    logic        addr_ok;
    logic        hit_ctrl;
    logic        hit_pre;
    logic        hit_low;
    logic        hit_high;
    logic        hit_any;
    logic        wr_lane;
    logic        high_run;
    logic        low_run;
    logic        len16;
    logic        low_step;
    logic        low_eq;
    logic        high_eq;
    logic        full_match;
    logic        low_match;
    logic        high_match;
    logic        high_step;
    logic [7:0]  ctrl_wr;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Only aligned words decode; anything else answers with an error
    assign addr_ok  = (paddr_in[1:0] == 2'b00);
    assign hit_ctrl = addr_ok && (paddr_in[dbmt_pkg::ADDR_W-1:2] == dbmt_pkg::IDX_TIMER_CONTROL);
    assign hit_pre  = addr_ok && (paddr_in[dbmt_pkg::ADDR_W-1:2] == dbmt_pkg::IDX_PRESCALER);
    assign hit_low  = addr_ok && (paddr_in[dbmt_pkg::ADDR_W-1:2] == dbmt_pkg::IDX_LOW_DATA);
    assign hit_high = addr_ok && (paddr_in[dbmt_pkg::ADDR_W-1:2] == dbmt_pkg::IDX_HIGH_DATA);
    assign hit_any  = hit_ctrl || hit_pre || hit_low || hit_high;
    // Registers live in byte lane 0, so only its strobe commits a write
    assign wr_lane  = psel_in && penable_in && pwrite_in && pstrb_in[0];

    // ****************************************************************
    // Control decode
    // ****************************************************************
    assign high_run = st_q.control[dbmt_pkg::BIT_HIGH_RUN];
    assign low_run  = st_q.control[dbmt_pkg::BIT_LOW_RUN];
    assign len16    = st_q.control[dbmt_pkg::BIT_LENGTH_SELECT];

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    // Either byte running keeps the shared prescaler alive
    assign pre_if.run       = high_run || low_run;
    // A write of the prescaler match value starts a fresh period
    assign pre_if.restart   = wr_lane && hit_pre;
    assign pre_if.match_val = st_q.pre_match;

    dbmt_prescaler u_prescaler (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .pre_if     (pre_if)
    );

    // ****************************************************************
    // Match events
    // ****************************************************************
    assign low_step   = pre_if.tick && low_run;
    assign low_eq     = (st_q.low_cnt == st_q.low_buf);
    assign high_eq    = (st_q.high_cnt == st_q.high_buf);
    // Cascaded mode compares the whole sixteen-bit value at once
    assign full_match = low_step && low_eq && high_eq;
    assign low_match  = len16 ? full_match : (low_step && low_eq);
    assign high_match = len16 ? (full_match && high_run)
                              : (pre_if.tick && high_run && high_eq);
    // In cascaded mode the high byte advances on the low byte carry
    assign high_step  = high_run && (len16 ? (low_step && (st_q.low_cnt == dbmt_pkg::CNT_TOP)
                                              && !full_match)
                                           : pre_if.tick);

    // ****************************************************************
    // Control write value
    // ****************************************************************
    // Flags can only be cleared by software; a written 1 leaves them as they are
    always_comb begin
        ctrl_wr = pwdata_in[7:0];
        ctrl_wr[dbmt_pkg::BIT_HIGH_FLAG] = st_q.control[dbmt_pkg::BIT_HIGH_FLAG]
                                           && pwdata_in[dbmt_pkg::BIT_HIGH_FLAG];
        ctrl_wr[dbmt_pkg::BIT_LOW_FLAG]  = st_q.control[dbmt_pkg::BIT_LOW_FLAG]
                                           && pwdata_in[dbmt_pkg::BIT_LOW_FLAG];
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;

        // Register writes commit on the access edge; spare bit stored as is
        if (wr_lane && hit_ctrl) begin
            st_d.control = ctrl_wr;
        end
        if (wr_lane && hit_pre) begin
            st_d.pre_match = pwdata_in[7:0];
        end
        if (wr_lane && hit_low) begin
            st_d.low_data = pwdata_in[7:0];
        end
        if (wr_lane && hit_high) begin
            st_d.high_data = pwdata_in[7:0];
        end

        // Hardware set applied after the write so it wins the same cycle
        if (low_match) begin
            st_d.control[dbmt_pkg::BIT_LOW_FLAG] = 1'b1;
        end
        if (high_match) begin
            st_d.control[dbmt_pkg::BIT_HIGH_FLAG] = 1'b1;
        end

        // Low byte counter
        if (!low_run || low_match) begin
            st_d.low_cnt = dbmt_pkg::CNT_ZERO;
        end else if (low_step) begin
            st_d.low_cnt = st_q.low_cnt + dbmt_pkg::CNT_ONE;
        end

        // High byte counter
        if (!high_run || high_match) begin
            st_d.high_cnt = dbmt_pkg::CNT_ZERO;
        end else if (high_step) begin
            st_d.high_cnt = st_q.high_cnt + dbmt_pkg::CNT_ONE;
        end

        // Match buffers: transparent while stopped, reloaded on match while running
        if (!low_run || low_match) begin
            st_d.low_buf = st_q.low_data;
        end
        if (!high_run || high_match) begin
            st_d.high_buf = st_q.high_data;
        end

        // Read data is latched in the setup cycle so prdata comes from flops
        if (psel_in && !penable_in) begin
            st_d.slverr = !hit_any;
            unique case (1'b1)
                hit_ctrl: st_d.rdata = st_q.control;
                hit_pre:  st_d.rdata = st_q.pre_match;
                hit_low:  st_d.rdata = st_q.low_data;
                hit_high: st_d.rdata = st_q.high_data;
                default:  st_d.rdata = dbmt_pkg::CNT_ZERO;
            endcase
        end
    end

    // State register; all software registers come up as zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q           <= '0;
            st_q.control   <= dbmt_pkg::RST_CONTROL;
            st_q.pre_match <= dbmt_pkg::RST_PRESCALER;
            st_q.low_data  <= dbmt_pkg::RST_MATCH_DATA;
            st_q.high_data <= dbmt_pkg::RST_MATCH_DATA;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Zero wait states: every access phase completes at once
    assign pready_out   = psel_in && penable_in;
    assign pslverr_out  = psel_in && penable_in && st_q.slverr;
    assign prdata_out   = {dbmt_pkg::RD_PAD, st_q.rdata};
    // Levels held while flag and enable are both set
    assign irq_high_out = st_q.control[dbmt_pkg::BIT_HIGH_FLAG]
                          && st_q.control[dbmt_pkg::BIT_HIGH_IE];
    assign irq_low_out  = st_q.control[dbmt_pkg::BIT_LOW_FLAG]
                          && st_q.control[dbmt_pkg::BIT_LOW_IE];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_pre_tick_value;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        pre_if.tick |-> (pre_if.count == st_q.pre_match) && pre_if.run;
    endproperty
    a_pre_tick_value: assert property (p_pre_tick_value)
        else $error("Prescaler ticked away from its match value");

    property p_pre_restart;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (pre_if.tick || pre_if.restart) |=> (pre_if.count == dbmt_pkg::CNT_ZERO);
    endproperty
    a_pre_restart: assert property (p_pre_restart)
        else $error("Prescaler did not restart from zero");

    property p_pre_stopped;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (!high_run && !low_run) [*2] |-> (pre_if.count == dbmt_pkg::CNT_ZERO) && !pre_if.tick;
    endproperty
    a_pre_stopped: assert property (p_pre_stopped)
        else $error("Prescaler moved while both bytes stopped");

    property p_low_held;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !low_run |=> (st_q.low_cnt == dbmt_pkg::CNT_ZERO);
    endproperty
    a_low_held: assert property (p_low_held)
        else $error("Stopped low counter not at zero");

    property p_high_held;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !high_run |=> (st_q.high_cnt == dbmt_pkg::CNT_ZERO);
    endproperty
    a_high_held: assert property (p_high_held)
        else $error("Stopped high counter not at zero");

    property p_high_clock8;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (!len16 && high_run && pre_if.tick && !high_eq)
            |=> (st_q.high_cnt == $past(st_q.high_cnt) + dbmt_pkg::CNT_ONE);
    endproperty
    a_high_clock8: assert property (p_high_clock8)
        else $error("High counter missed a prescaler tick");

    property p_low_period;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (low_match && low_run) ##1 low_run |-> (st_q.low_cnt == dbmt_pkg::CNT_ZERO);
    endproperty
    a_low_period: assert property (p_low_period)
        else $error("Low counter did not clear on match");

    property p_len16_both;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (len16 && low_match) |-> (st_q.low_cnt == st_q.low_buf) && (st_q.high_cnt == st_q.high_buf);
    endproperty
    a_len16_both: assert property (p_len16_both)
        else $error("Sixteen-bit match with unequal bytes");

    property p_low_buf_follow;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !low_run |=> (st_q.low_buf == $past(st_q.low_data));
    endproperty
    a_low_buf_follow: assert property (p_low_buf_follow)
        else $error("Low buffer not following its data register");

    property p_high_buf_keep;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (high_run && !high_match) |=> (st_q.high_buf == $past(st_q.high_buf));
    endproperty
    a_high_buf_keep: assert property (p_high_buf_keep)
        else $error("High buffer changed without a match");

    property p_high_flag_set;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        high_match |=> st_q.control[dbmt_pkg::BIT_HIGH_FLAG] ##1 (irq_high_out == st_q.control[dbmt_pkg::BIT_HIGH_IE]) || !st_q.control[dbmt_pkg::BIT_HIGH_FLAG];
    endproperty
    a_high_flag_set: assert property (p_high_flag_set)
        else $error("High flag not set by match");

    property p_low_flag_sticky;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_q.control[dbmt_pkg::BIT_LOW_FLAG] && !(wr_lane && hit_ctrl))
            |=> st_q.control[dbmt_pkg::BIT_LOW_FLAG];
    endproperty
    a_low_flag_sticky: assert property (p_low_flag_sticky)
        else $error("Low flag dropped without a write");

    property p_irq_low;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (low_match && st_q.control[dbmt_pkg::BIT_LOW_IE] && !(wr_lane && hit_ctrl)) |=> irq_low_out;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("Low interrupt not raised after match");

    property p_both_flags;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (len16 && high_run && low_match) |=> st_q.control[dbmt_pkg::BIT_LOW_FLAG]
                                            && st_q.control[dbmt_pkg::BIT_HIGH_FLAG];
    endproperty
    a_both_flags: assert property (p_both_flags)
        else $error("Sixteen-bit match did not set both flags");

    property p_set_wins;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (high_match && wr_lane && hit_ctrl) |=> st_q.control[dbmt_pkg::BIT_HIGH_FLAG];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Flag clear beat a hardware set");

endmodule
`default_nettype wire

// File: hw/dbmt_pkg.sv
// Purpose: Shared constants and state types of the dual byte match timer
// Assumes: APB slave with 32-bit data, 8-bit registers in the low byte lane
// Notes:   Register indexes are word indexes; byte address is four times the index
package dbmt_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned  ADDR_W            = 18;
    localparam logic [15:0]  IDX_TIMER_CONTROL = 16'hfef4;
    localparam logic [15:0]  IDX_PRESCALER     = 16'hfef5;
    localparam logic [15:0]  IDX_LOW_DATA      = 16'hfef6;
    localparam logic [15:0]  IDX_HIGH_DATA     = 16'hfef7;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int unsigned  BIT_HIGH_RUN      = 7;
    localparam int unsigned  BIT_LOW_RUN       = 6;
    localparam int unsigned  BIT_LENGTH_SELECT = 5;
    localparam int unsigned  BIT_USER_SPARE    = 4;
    localparam int unsigned  BIT_HIGH_FLAG     = 3;
    localparam int unsigned  BIT_HIGH_IE       = 2;
    localparam int unsigned  BIT_LOW_FLAG      = 1;
    localparam int unsigned  BIT_LOW_IE        = 0;

    // ****************************************************************
    // Reset values and counter constants
    // ****************************************************************
    localparam logic [7:0]   RST_CONTROL       = 8'h00;
    localparam logic [7:0]   RST_PRESCALER     = 8'h00;
    localparam logic [7:0]   RST_MATCH_DATA    = 8'h00;
    localparam logic [7:0]   CNT_ZERO          = 8'h00;
    localparam logic [7:0]   CNT_ONE           = 8'h01;
    localparam logic [7:0]   CNT_TOP           = 8'hff;
    localparam logic [23:0]  RD_PAD            = 24'h000000;

    // ****************************************************************
    // State types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] count;
    } dbmt_pre_state_s;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] pre_match;
        logic [7:0] low_data;
        logic [7:0] high_data;
        logic [7:0] low_cnt;
        logic [7:0] high_cnt;
        logic [7:0] low_buf;
        logic [7:0] high_buf;
        logic [7:0] rdata;
        logic       slverr;
    } dbmt_state_s;

endpackage

// File: hw/dbmt_pre_if.sv
// Purpose: Link between the timer core and its cycle-clock prescaler
// Assumes: Single clock domain
// Notes:   Tick is combinational from the prescaler count
`timescale 1ns/1ps
`default_nettype none
interface dbmt_pre_if;
    logic       run;
    logic       restart;
    logic [7:0] match_val;
    logic       tick;
    logic [7:0] count;

    modport ctrl (output run, output restart, output match_val, input tick, input count);
    modport pre  (input run, input restart, input match_val, output tick, output count);
endinterface
`default_nettype wire

// File: hw/dbmt_prescaler.sv
// Purpose: 8-bit programmable prescaler counting cycle clocks
// Assumes: Restart comes from the same clock domain
// Notes:   Tick period is match value plus one cycles
`timescale 1ns/1ps
`default_nettype none
module dbmt_prescaler (
    // Clock and reset
    input  wire logic   clk_sys_in,
    input  wire logic   rst_n_in,
    // Prescaler link
    dbmt_pre_if.pre     pre_if
);

    dbmt_pkg::dbmt_pre_state_s st_q;
    dbmt_pkg::dbmt_pre_state_s st_d;

    // ****************************************************************
    // Match detection
    // ****************************************************************
    // Match only while running, so a stopped prescaler never ticks
    assign pre_if.tick  = pre_if.run && (st_q.count == pre_if.match_val);
    assign pre_if.count = st_q.count;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Stop, match and a new match value all restart from zero
    always_comb begin
        st_d = st_q;
        if (!pre_if.run || pre_if.tick || pre_if.restart) begin
            st_d.count = dbmt_pkg::CNT_ZERO;
        end else begin
            st_d.count = st_q.count + dbmt_pkg::CNT_ONE;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule
`default_nettype wire

// File: test/test_dual_byte_match_timer.sv
// Purpose: Self-checking bench for the dual byte match timer
// Assumes: Zero-wait APB slave; a match flag rises at the edge that ends a period
// Notes:   Reads are checked by a monitor against a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module test_dual_byte_match_timer;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    logic        clk_sys_in;
    logic        rst_n_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [17:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [3:0]  pstrb_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        irq_high_out;
    logic        irq_low_out;
    logic [32:0] exp_q[$];
    int          bad_count;
    int          total_checks;
    int          seed;
    int          pv;
    int          rv;

    dbmt_timer dbmt_timer_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_high_out(irq_high_out),
        .irq_low_out(irq_low_out));

    // 20 MHz cycle clock
    always #25 clk_sys_in = ~clk_sys_in;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; a spare edge after release keeps strobes from being reassigned
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       input logic [3:0] s);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= {idx, 2'b00};
        pwdata_in  <= d;
        pstrb_in   <= s;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1) @(posedge clk_sys_in);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [15:0] idx, input int d);
        apb(1'b1, idx, 32'(d), 4'hf);
    endtask

    // Note the expected answer first, the monitor compares it
    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic err);
        exp_q.push_back({err, 24'h000000, exp});
        apb(1'b0, idx, 32'h0, 4'h0);
    endtask

    // Cycles from the run write edge until the selected request rises
    task automatic period(input logic hi, input int exp);
        int n;
        #1;
        n = 1;
        while ((hi ? irq_high_out : irq_low_out) !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check("period", 33'(n), 33'(exp));
    endtask

    // Read monitor: every completed read retires the oldest note
    always @(posedge clk_sys_in) begin
        if (psel_in && penable_in && pready_out && !pwrite_in) begin
            check("queue", 33'(exp_q.size() > 0), 33'h1);
            if (exp_q.size() > 0) begin
                check("read", {pslverr_out, prdata_out}, exp_q.pop_front());
            end
        end
    end

    // Watchdog well beyond the longest 16-bit period
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk_sys_in = 1'b0;
        rst_n_in = 1'b0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
        bad_count = 0;
        total_checks = 0;
        seed = 82;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(dbmt_pkg::IDX_TIMER_CONTROL, 8'h00, 1'b0);
        rd(dbmt_pkg::IDX_PRESCALER, 8'h00, 1'b0);
        rd(dbmt_pkg::IDX_LOW_DATA, 8'h00, 1'b0);
        rd(dbmt_pkg::IDX_HIGH_DATA, 8'h00, 1'b0);
        rd(16'h0000, 8'h00, 1'b1);
        // Spare bit sticks, flags cannot be set by software
        wr(dbmt_pkg::IDX_TIMER_CONTROL, 8'h1a);
        rd(dbmt_pkg::IDX_TIMER_CONTROL, 8'h10, 1'b0);
        apb(1'b1, dbmt_pkg::IDX_LOW_DATA, 32'h55, 4'h0);
        rd(dbmt_pkg::IDX_LOW_DATA, 8'h00, 1'b0);
        // 8-bit mode, low and high byte in turn, random periods
        for (int t = 0; t < 4; t++) begin
            pv = $random(seed) & 3;
            rv = ($random(seed) & 7) + 1;
            wr(dbmt_pkg::IDX_PRESCALER, pv);
            wr(t[0] ? dbmt_pkg::IDX_HIGH_DATA : dbmt_pkg::IDX_LOW_DATA, rv);
            wr(dbmt_pkg::IDX_TIMER_CONTROL, t[0] ? 8'h84 : 8'h41);
            period(t[0], (rv + 1) * (pv + 1));
            check("other irq", 33'(t[0] ? irq_low_out : irq_high_out), 33'h0);
            wr(dbmt_pkg::IDX_TIMER_CONTROL, 8'h00);
            #1;
            check("irq clear", 33'({irq_high_out, irq_low_out}), 33'h0);
            rd(dbmt_pkg::IDX_TIMER_CONTROL, 8'h00, 1'b0);
        end
        // 16-bit mode: high byte steps only on low carry, both flags together
        pv = $random(seed) & 3;
        rv = $random(seed) & 8'hff;
        wr(dbmt_pkg::IDX_PRESCALER, pv);
        wr(dbmt_pkg::IDX_LOW_DATA, rv);
        wr(dbmt_pkg::IDX_HIGH_DATA, 1);
        wr(dbmt_pkg::IDX_TIMER_CONTROL, 8'he5);
        period(1'b0, (257 + rv) * (pv + 1));
        check("both irq", 33'(irq_high_out), 33'h1);
        rd(dbmt_pkg::IDX_TIMER_CONTROL, 8'hef, 1'b0);
        wr(dbmt_pkg::IDX_TIMER_CONTROL, 8'h00);
        rd(dbmt_pkg::IDX_TIMER_CONTROL, 8'h00, 1'b0);
        check("queue empty", 33'(exp_q.size()), 33'h0);
        end_sim();
    end
endmodule
`default_nettype wire
